// File: hdl/ssu_pkg.sv
// constants, types and register map of the synchronous serial unit
// assumes a 40 MHz sys_clk and an instruction cycle of three clocks
package ssu_pkg;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [15:0] IDX_SERIAL_CONTROL = 16'hFE30;
  localparam logic [15:0] IDX_SHIFT_BUFFER   = 16'hFE31;
  localparam logic [15:0] IDX_CLOCK_DIVIDER  = 16'hFE32;
  localparam logic [15:0] IDX_BIT_LENGTH     = 16'hFE33;
  localparam logic [15:0] IDX_BURST_CONTROL  = 16'hFE37;
  localparam logic [15:0] IDX_PIN_CONTROL    = 16'hFE38;
  localparam logic [15:0] IDX_RAM_FIRST      = 16'h01C0;
  localparam logic [15:0] IDX_RAM_LAST       = 16'h01FF;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_BANK    = 7;
  localparam int BIT_SWAP    = 6;
  localparam int BIT_RUN     = 5;
  localparam int BIT_BURST   = 4;
  localparam int BIT_MSB     = 3;
  localparam int BIT_OVR     = 2;
  localparam int BIT_END     = 1;
  localparam int BIT_IE      = 0;
  localparam int BIT_PAUSE   = 7;
  localparam int BIT_SPARE6  = 6;
  localparam int BIT_SPARE5  = 5;
  localparam int BIT_INTCLK  = 0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [4:0] RST_COUNT   = 5'h00;
  localparam logic       RST_SCLK    = 1'b1;

  // ****************************************
  // timing
  // ****************************************
  localparam int TCYC_NS    = 75;
  localparam int SYS_CLK_NS = 25;
  // half serial period is (n+1)*(2/3 Tcyc)/2 = (n+1)*HALF_MULT clocks
  localparam int HALF_MULT  = (2 * TCYC_NS) / (2 * 3 * SYS_CLK_NS);
  localparam logic [8:0] SINGLE_BITS = 9'h008;
  localparam logic [2:0] LAST_BIT_OF_BYTE = 3'h7;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SHIFT, ST_HOLD} ssu_state_e;

  typedef struct packed {
    logic sclkOut;
    logic sclkOe;
    logic sdataOut;
  } ssu_pins_s;

  typedef struct packed {
    logic       we;
    logic [5:0] idx;
    logic [7:0] data;
  } ssu_ramw_s;

endpackage

// File: hdl/ssu_baud_div.sv
// reload divider that paces the internal serial clock
// assumes run is held for the whole shifting phase
`timescale 1ns/1ps
module ssu_baud_div
  import ssu_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // control
  input  wire logic       run,
  input  wire logic [7:0] divider,
  // half-period pulse
  output logic            tick
);

  logic [8:0] cnt_reg;
  logic [8:0] reload;

  // a divider of zero is allowed; it simply toggles every clock
  assign reload = 9'((({1'b0, divider} + 9'h001) * HALF_MULT) - 1);
  assign tick   = run && (cnt_reg == 9'h000);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      cnt_reg <= 9'h000;
    else if (!run || tick)
      cnt_reg <= reload;
    else
      cnt_reg <= cnt_reg - 9'h001;
  end

endmodule

// File: hdl/ssu_ram_bank.sv
// 64-byte transfer RAM, two 32-byte banks, flip-flop storage
// serial side write wins when both sides hit the same cycle
`timescale 1ns/1ps
module ssu_ram_bank
  import ssu_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // cpu side
  input  wire ssu_ramw_s  cpuW,
  output logic [7:0]      cpuRdata,
  // serial side
  input  wire ssu_ramw_s  serW,
  output logic [7:0]      serRdata
);

  logic [7:0] mem [64];

  genvar i;
  generate
    for (i = 0; i < 64; i++)
    begin : g_entry
      always_ff @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
          mem[i] <= RST_BYTE;
        else if (serW.we && serW.idx == 6'(i))
          mem[i] <= serW.data;
        else if (cpuW.we && cpuW.idx == 6'(i))
          mem[i] <= cpuW.data;
      end
    end
  endgenerate

  assign cpuRdata = mem[cpuW.idx];
  assign serRdata = mem[serW.idx];

endmodule

// File: hdl/ssu_sync_serial.sv
// synchronous serial unit: 8-bit and RAM-fed burst transfer, APB slave
// assumes serial pins are synchronous to sys_clk, APB on the same clock
`timescale 1ns/1ps

// Functional notes
// - serial period (n+1) times two-thirds cycle
// - shift register transmits and receives together
// - bank bit selects upper or lower window
// - swap bit exchanges, else copies RAM
// - software sets run, hardware clears at end
// - burst mode bit cleared at transfer end
// - bit order select MSB or LSB first
// - clock fall while idle sets overrun
// - clock fall during RAM exchange sets overrun
// - end flag set at end, software clears
// - interrupt when enable and end both set
// - burst length is bit-length value plus one
// - pause bit halts after current byte
// - two spare bits freely read and written
// - read-only count of bytes transferred
// - first RAM byte loaded before shifting
// - next RAM byte loaded every 8 bits
// - last partial byte stays in shift register
// - burst covers 1 to 256 bits
// - single mode keeps running during halt
// - cpu halt pauses burst before exchange
module ssu_sync_serial
  import ssu_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // cpu state
  input  wire logic        cpuHalt,
  output logic             irq,
  // serial pins
  input  wire logic        sclkIn,
  input  wire logic        sdataIn,
  output ssu_pins_s        pins
);

  // ****************************************
  // storage
  // ****************************************
  logic        bank_reg, swap_reg, run_reg, burst_reg, msb_reg;
  logic        ovr_reg, end_reg, ie_reg;
  logic [7:0]  shift_reg, divider_reg, bitLen_reg;
  logic        pause_reg, spare6_reg, spare5_reg, intClk_reg;
  logic [4:0]  bytes_reg;
  logic [4:0]  addr_reg;
  logic [8:0]  bitsLeft_reg;
  logic [2:0]  bitInByte_reg;
  logic        sclkPrev_reg;
  ssu_state_e  state_reg;
  ssu_pins_s   pins_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg, pslverr_reg, irq_reg;

  // ****************************************
  // apb decode
  // ****************************************
  logic        access, wrEn;
  logic [15:0] idx;
  logic        hitCtl, hitBuf, hitDiv, hitLen, hitBst, hitPin, hitRam;
  logic [7:0]  rdByte, ramCpuRdata, ramSerRdata;
  ssu_ramw_s   cpuW, serW;

  assign access = psel && penable;
  assign wrEn   = access && pwrite && pready_reg;
  assign idx    = paddr[17:2];

  always_comb
  begin
    hitCtl = 1'b0;
    hitBuf = 1'b0;
    hitDiv = 1'b0;
    hitLen = 1'b0;
    hitBst = 1'b0;
    hitPin = 1'b0;
    hitRam = 1'b0;
    if (paddr[1:0] != 2'b00)
      hitCtl = 1'b0;
    else if (idx == IDX_SERIAL_CONTROL)
      hitCtl = 1'b1;
    else if (idx == IDX_SHIFT_BUFFER)
      hitBuf = 1'b1;
    else if (idx == IDX_CLOCK_DIVIDER)
      hitDiv = 1'b1;
    else if (idx == IDX_BIT_LENGTH)
      hitLen = 1'b1;
    else if (idx == IDX_BURST_CONTROL)
      hitBst = 1'b1;
    else if (idx == IDX_PIN_CONTROL)
      hitPin = 1'b1;
    else if (idx >= IDX_RAM_FIRST && idx <= IDX_RAM_LAST)
      hitRam = 1'b1;
  end

  always_comb
  begin
    rdByte = 8'h00;
    if (hitCtl)
      rdByte = {bank_reg, swap_reg, run_reg, burst_reg,
                msb_reg, ovr_reg, end_reg, ie_reg};
    else if (hitBuf)
      rdByte = shift_reg;
    else if (hitDiv)
      rdByte = divider_reg;
    else if (hitLen)
      rdByte = bitLen_reg;
    else if (hitBst)
      rdByte = {pause_reg, spare6_reg, spare5_reg, bytes_reg};
    else if (hitPin)
      rdByte = {7'h00, intClk_reg};
    else if (hitRam)
      rdByte = ramCpuRdata;
  end

  // one wait state keeps every bus output on a flip-flop
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= access && !pready_reg;
      if (access && !pready_reg)
      begin
        prdata_reg  <= {24'h00_0000, rdByte};
        pslverr_reg <= !(hitCtl || hitBuf || hitDiv || hitLen ||
                         hitBst || hitPin || hitRam);
      end
      else
        pslverr_reg <= 1'b0;
    end
  end

  // ****************************************
  // serial clock and edges
  // ****************************************
  logic sclkNow, rise, fall, tick, lastBit, byteEnd;

  assign sclkNow = intClk_reg ? pins_reg.sclkOut : sclkIn;
  assign rise    = sclkNow && !sclkPrev_reg;
  assign fall    = !sclkNow && sclkPrev_reg;
  assign lastBit = (state_reg == ST_SHIFT) && rise &&
                   (bitsLeft_reg == 9'h001);
  assign byteEnd = (state_reg == ST_SHIFT) && rise && !lastBit &&
                   burst_reg && (bitInByte_reg == LAST_BIT_OF_BYTE);

  ssu_baud_div u_div (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .run     (intClk_reg && state_reg == ST_SHIFT),
    .divider (divider_reg),
    .tick    (tick)
  );

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      sclkPrev_reg <= RST_SCLK;
    else
      sclkPrev_reg <= sclkNow;
  end

  // internal clock idles high and toggles only while shifting
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      pins_reg <= '{sclkOut: RST_SCLK, sclkOe: 1'b0, sdataOut: 1'b1};
    else
    begin
      pins_reg.sclkOe <= intClk_reg;
      if (state_reg != ST_SHIFT)
        pins_reg.sclkOut <= RST_SCLK;
      else if (tick)
        pins_reg.sclkOut <= !pins_reg.sclkOut;
      if (fall)
        pins_reg.sdataOut <= msb_reg ? shift_reg[7] : shift_reg[0];
    end
  end

  // ****************************************
  // transfer sequencer
  // ****************************************
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg     <= ST_IDLE;
      bitsLeft_reg  <= 9'h000;
      bitInByte_reg <= 3'h0;
      addr_reg      <= 5'h00;
      bytes_reg     <= RST_COUNT;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (run_reg && burst_reg)
          begin
            state_reg     <= ST_LOAD;
            bitsLeft_reg  <= {1'b0, bitLen_reg} + 9'h001;
            bitInByte_reg <= 3'h0;
            addr_reg      <= 5'h00;
            bytes_reg     <= RST_COUNT;
          end
          else if (run_reg)
          begin
            state_reg     <= ST_SHIFT;
            bitsLeft_reg  <= SINGLE_BITS;
            bitInByte_reg <= 3'h0;
          end
        ST_LOAD:
        begin
          state_reg <= ST_SHIFT;
          addr_reg  <= addr_reg + 5'h01;
        end
        ST_SHIFT:
          if (rise)
          begin
            bitsLeft_reg  <= bitsLeft_reg - 9'h001;
            bitInByte_reg <= bitInByte_reg + 3'h1;
            if (lastBit)
              state_reg <= ST_IDLE;
            else if (byteEnd)
            begin
              bytes_reg <= bytes_reg + 5'h01;
              // single mode ignores halt so its interrupt can wake the cpu
              if (pause_reg || cpuHalt)
                state_reg <= ST_HOLD;
              else
                state_reg <= ST_LOAD;
            end
          end
        ST_HOLD:
          if (!pause_reg && !cpuHalt)
            state_reg <= ST_LOAD;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // shift register and RAM exchange
  // ****************************************
  assign serW.idx  = {bank_reg, addr_reg};
  assign serW.we   = (state_reg == ST_LOAD) && swap_reg;
  assign serW.data = shift_reg;
  assign cpuW.idx  = idx[5:0];
  assign cpuW.we   = wrEn && hitRam;
  assign cpuW.data = pwdata[7:0];

  ssu_ram_bank u_ram (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .cpuW     (cpuW),
    .cpuRdata (ramCpuRdata),
    .serW     (serW),
    .serRdata (ramSerRdata)
  );

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      shift_reg <= RST_BYTE;
    else if (state_reg == ST_LOAD)
      shift_reg <= ramSerRdata;
    else if (state_reg == ST_SHIFT && rise)
      shift_reg <= msb_reg ? {shift_reg[6:0], sdataIn}
                           : {sdataIn, shift_reg[7:1]};
    else if (wrEn && hitBuf)
      shift_reg <= pwdata[7:0];
  end

  // ****************************************
  // control registers and flags
  // ****************************************
  logic ovrEvent;
  assign ovrEvent = fall && (!run_reg || state_reg == ST_LOAD);

  // hardware set and clear win over a write in the same cycle
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {bank_reg, swap_reg, msb_reg, ie_reg} <= 4'h0;
      {run_reg, burst_reg, ovr_reg, end_reg} <= 4'h0;
    end
    else
    begin
      if (wrEn && hitCtl)
      begin
        bank_reg <= pwdata[BIT_BANK];
        swap_reg <= pwdata[BIT_SWAP];
        msb_reg  <= pwdata[BIT_MSB];
        ie_reg   <= pwdata[BIT_IE];
      end
      if (lastBit)
        run_reg <= 1'b0;
      else if (wrEn && hitCtl)
        run_reg <= pwdata[BIT_RUN];
      if (lastBit)
        burst_reg <= 1'b0;
      else if (wrEn && hitCtl)
        burst_reg <= pwdata[BIT_BURST];
      if (ovrEvent)
        ovr_reg <= 1'b1;
      else if (wrEn && hitCtl)
        ovr_reg <= pwdata[BIT_OVR];
      if (lastBit)
        end_reg <= 1'b1;
      else if (wrEn && hitCtl)
        end_reg <= pwdata[BIT_END];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      divider_reg <= RST_BYTE;
      bitLen_reg  <= RST_BYTE;
      {pause_reg, spare6_reg, spare5_reg, intClk_reg} <= 4'h0;
    end
    else if (wrEn)
    begin
      if (hitDiv)
        divider_reg <= pwdata[7:0];
      if (hitLen)
        bitLen_reg <= pwdata[7:0];
      if (hitBst)
      begin
        pause_reg  <= pwdata[BIT_PAUSE];
        spare6_reg <= pwdata[BIT_SPARE6];
        spare5_reg <= pwdata[BIT_SPARE5];
      end
      if (hitPin)
        intClk_reg <= pwdata[BIT_INTCLK];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      irq_reg <= 1'b0;
    else
      irq_reg <= ie_reg && end_reg;
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq     = irq_reg;
  assign pins    = pins_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  end_set_a: assert property (lastBit |=> end_reg)
    else $error("end flag not set at last bit");
  run_clear_a: assert property (lastBit |=> !run_reg && state_reg == ST_IDLE)
    else $error("run flag not cleared at end");
  mode_clear_a: assert property (lastBit |=> !burst_reg)
    else $error("burst mode bit not cleared at end");
  ovr_set_a: assert property (fall && state_reg == ST_LOAD |=> ovr_reg)
    else $error("overrun missed during exchange");
  idle_ovr_a: assert property (fall && !run_reg |=> ovr_reg)
    else $error("overrun missed while idle");
  irq_a: assert property (ie_reg && end_reg ##1 ie_reg && end_reg |-> irq_reg)
    else $error("interrupt not raised");
  first_load_a: assert property (state_reg == ST_IDLE && run_reg && burst_reg
    |=> state_reg == ST_LOAD && addr_reg == 5'h00)
    else $error("burst did not start with a RAM load");
  pause_a: assert property (byteEnd && pause_reg |=> state_reg == ST_HOLD)
    else $error("pause not honoured at byte end");
  halt_hold_a: assert property (state_reg == ST_HOLD && cpuHalt
    |=> state_reg == ST_HOLD)
    else $error("transfer resumed during halt");
  swap_only_a: assert property (serW.we |-> swap_reg && state_reg == ST_LOAD)
    else $error("RAM written without swap");

  single_end_c: cover property (lastBit && !burst_reg);
  burst_end_c: cover property (lastBit && burst_reg && bytes_reg != 5'h00);
  pause_c: cover property (state_reg == ST_HOLD ##1 state_reg == ST_LOAD);

endmodule

// File: verif/ssu_peer.sv
// far-side serial peer: drives receive data, samples transmit data
// assumes the resolved serial clock wire and sys_clk from the bench
`timescale 1ns/1ps
module ssu_peer
#(
  parameter int HALF = 4
)
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // serial line
  input  wire logic        sclk,
  input  wire logic        sdo,
  output logic             sdi,
  output logic             extClk,
  // bench control
  input  wire logic        start,
  input  wire logic [8:0]  nPulses,
  input  wire logic [31:0] txBits,
  output logic [31:0]      rxBits,
  output logic [9:0]       period
);
  logic        sclk_reg;
  logic [31:0] txSh_reg;
  logic [9:0]  left_reg;
  logic [7:0]  cnt_reg;
  logic [9:0]  since_reg;

  // ****************************************
  // clock source and bit exchange
  // ****************************************
  // external clock idles high and only runs inside a frame
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      sclk_reg  <= 1'b1;
      sdi       <= 1'b1;
      extClk    <= 1'b1;
      txSh_reg  <= 32'h0;
      rxBits    <= 32'h0;
      left_reg  <= 10'h0;
      cnt_reg   <= 8'h0;
      since_reg <= 10'h0;
      period    <= 10'h0;
    end
    else
    begin
      sclk_reg  <= sclk;
      since_reg <= since_reg + 10'h1;
      if (start)
      begin
        txSh_reg <= txBits;
        rxBits   <= 32'h0;
        left_reg <= {nPulses, 1'b0};
        cnt_reg  <= 8'h0;
      end
      else if (left_reg != 10'h0)
      begin
        if (cnt_reg == 8'(HALF - 1))
        begin
          cnt_reg  <= 8'h0;
          extClk   <= ~extClk;
          left_reg <= left_reg - 10'h1;
        end
        else
          cnt_reg <= cnt_reg + 8'h1;
      end
      if (sclk_reg && !sclk)
      begin
        sdi       <= txSh_reg[31];
        txSh_reg  <= {txSh_reg[30:0], 1'b0};
        period    <= since_reg;
        since_reg <= 10'h1;
      end
      if (!sclk_reg && sclk)
        rxBits <= {rxBits[30:0], sdo};
    end
endmodule

// File: verif/sync_serial_with_ram_burst_test.sv
// self-checking bench of the synchronous serial unit
// assumes the APB slave answers with pready and a peer on the serial pins
`timescale 1ns/1ps
module sync_serial_with_ram_burst_test
  import ssu_pkg::*;
();
  `define CHK(got, exp) \
    begin \
      checkCount++; \
      if ((got) !== (exp)) \
      begin \
        fails++; \
        $display("wrong value at %0t: got %h want %h", $time, got, exp); \
      end \
    end
  logic        sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic        cpuHalt, irq, sdi, extClk, sclkWire, start;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, txBits, rxBits;
  logic [8:0]  nPulses;
  logic [9:0]  period;
  ssu_pins_s   pins;
  int          fails, checkCount;

  // the pin carries whichever side drives the clock
  assign sclkWire = pins.sclkOe ? pins.sclkOut : extClk;

  ssu_sync_serial i_dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpuHalt(cpuHalt), .irq(irq), .sclkIn(sclkWire), .sdataIn(sdi),
    .pins(pins));
  ssu_peer i_peer (.sys_clk(sys_clk), .rstn(rstn), .sclk(sclkWire),
    .sdo(pins.sdataOut), .sdi(sdi), .extClk(extClk), .start(start),
    .nPulses(nPulses), .txBits(txBits), .rxBits(rxBits), .period(period));

  // ****************************************
  // bus and peer tasks
  // ****************************************
  task automatic conclude;
    if (fails == 0 && checkCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 50)
    begin
      fails++;
      conclude();
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, idx, d, rd, e);
  endtask

  task automatic rdChk(input logic [15:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, idx, 8'h00, rd, e);
    `CHK(rd, {24'h0, exp})
  endtask

  // polling the run bit is bounded; a stuck transfer ends the run
  task automatic waitDone;
    logic [31:0] rd;
    logic        e;
    int          n;
    n = 0;
    do
    begin
      apb(1'b0, IDX_SERIAL_CONTROL, 8'h00, rd, e);
      n++;
    end
    while (rd[BIT_RUN] !== 1'b0 && n < 400);
    if (n == 400)
    begin
      fails++;
      conclude();
    end
  endtask

  task automatic peerGo(input logic [31:0] tx, input logic [8:0] np);
    @(posedge sys_clk);
    txBits  <= tx;
    nPulses <= np;
    start   <= 1'b1;
    @(posedge sys_clk);
    start   <= 1'b0;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic tReset;
    logic [31:0] rd;
    logic        e;
    rdChk(IDX_SERIAL_CONTROL, RST_BYTE);
    rdChk(IDX_SHIFT_BUFFER, RST_BYTE);
    rdChk(IDX_CLOCK_DIVIDER, RST_BYTE);
    rdChk(IDX_BIT_LENGTH, RST_BYTE);
    rdChk(IDX_BURST_CONTROL, RST_BYTE);
    apb(1'b0, 16'hFE34, 8'h00, rd, e);
    `CHK({e, rd}, {1'b1, 32'h0})
    wr(IDX_BURST_CONTROL, 8'h7F);
    rdChk(IDX_BURST_CONTROL, 8'h60);
    wr(IDX_BURST_CONTROL, 8'h00);
    `CHK(pins.sclkOut, RST_SCLK)
  endtask

  task automatic tSingle;
    wr(IDX_PIN_CONTROL, 8'h01);
    wr(IDX_CLOCK_DIVIDER, 8'h02);
    wr(IDX_SHIFT_BUFFER, 8'hA5);
    peerGo(32'h3C00_0000, 9'h000);
    wr(IDX_SERIAL_CONTROL, 8'h29);
    waitDone();
    `CHK(rxBits[7:0], 8'hA5)
    `CHK(period, 10'h006)
    rdChk(IDX_SHIFT_BUFFER, 8'h3C);
    rdChk(IDX_SERIAL_CONTROL, 8'h0B);
    `CHK(irq, 1'b1)
    wr(IDX_SERIAL_CONTROL, 8'h09);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
  endtask

  task automatic tExt;
    wr(IDX_PIN_CONTROL, 8'h00);
    wr(IDX_SHIFT_BUFFER, 8'h96);
    wr(IDX_SERIAL_CONTROL, 8'h20);
    peerGo(32'h0D00_0000, 9'h008);
    waitDone();
    `CHK(rxBits[7:0], 8'h69)
    rdChk(IDX_SHIFT_BUFFER, 8'hB0);
    rdChk(IDX_SERIAL_CONTROL, 8'h02);
    peerGo(32'h0, 9'h001);
    repeat (12) @(posedge sys_clk);
    rdChk(IDX_SERIAL_CONTROL, 8'h06);
    wr(IDX_SERIAL_CONTROL, 8'h00);
    rdChk(IDX_SERIAL_CONTROL, 8'h00);
  endtask

  // twelve bits: one whole byte through RAM, then a partial byte
  task automatic tBurst(input logic bank, input logic swap);
    logic [15:0] base;
    base = bank ? 16'h01E0 : IDX_RAM_FIRST;
    wr(base ^ 16'h0020, 8'h00);
    wr(base, 8'hC3);
    wr(base + 16'h0001, 8'h5A);
    wr(IDX_SHIFT_BUFFER, 8'h11);
    wr(IDX_PIN_CONTROL, 8'h01);
    wr(IDX_CLOCK_DIVIDER, 8'h01);
    wr(IDX_BIT_LENGTH, 8'h0B);
    peerGo(32'hE790_0000, 9'h000);
    wr(IDX_SERIAL_CONTROL, {bank, swap, 6'b111000});
    waitDone();
    `CHK(rxBits[11:0], 12'hC35)
    rdChk(IDX_BURST_CONTROL, 8'h01);
    rdChk(base, swap ? 8'h11 : 8'hC3);
    rdChk(base + 16'h0001, swap ? 8'hE7 : 8'h5A);
    rdChk(IDX_SHIFT_BUFFER, 8'hA9);
    rdChk(IDX_SERIAL_CONTROL, {bank, swap, 6'b001010});
  endtask

  // ****************************************
  // clock, reset and sequence
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    conclude();
  end

  initial
  begin
    fails      = 0;
    checkCount = 0;
    rstn       = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 18'h0;
    pwdata     = 32'h0;
    cpuHalt    = 1'b0;
    start      = 1'b0;
    txBits     = 32'h0;
    nPulses    = 9'h000;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    tReset();
    tSingle();
    tExt();
    tBurst(1'b1, 1'b1);
    tBurst(1'b0, 1'b0);
    conclude();
  end
endmodule
